//--- hw/shared_boundary_scan_pins.v
// Functional notes
// - Sample TDI on each test clock rise
// - Drive scan data out on TDO
// - Not in test: all four pins are user I/O
// - Flexible: mode select low enters test
// - Test mode held until logic-reset state
// - Five high mode clocks reach logic reset
// - Dedicated: mode select drives TAP only
`timescale 1ns/1ps
`include "scan_pins_consts.vh"
module shared_boundary_scan_pins (
  input  wire                  sys_clk_in,
  input  wire                  sys_rst_in,
  input  wire                  reserve_pins_in,
  input  wire                  tck_pad_in,
  input  wire                  tdi_pad_in,
  input  wire                  tms_pad_in,
  input  wire                  tdo_pad_in,
  output reg                   tck_pad_out,
  output reg                   tck_pad_oe_out,
  output reg                   tdi_pad_out,
  output reg                   tdi_pad_oe_out,
  output reg                   tms_pad_out,
  output reg                   tms_pad_oe_out,
  output reg                   tdo_pad_out,
  output reg                   tdo_pad_oe_out,
  input  wire [3:0]            user_out_in,
  input  wire [3:0]            user_oe_in,
  output reg  [3:0]            user_in_out,
  input  wire [`BSR_W-1:0]     bsr_capture_in,
  output reg  [`BSR_W-1:0]     bsr_update_out,
  output reg                   test_active_out,
  output wire [`TAP_W-1:0]     tap_state_out
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg  [3:0] meta_r;
  reg  [3:0] sync_r;
  reg        tck_prev_r;
  reg        reserve_r;
  wire       tck_s = sync_r[0];
  wire       tdi_s = sync_r[1];
  wire       tms_s = sync_r[2];
  wire       tck_rise = tck_s & ~tck_prev_r;
  wire       tck_fall = ~tck_s & tck_prev_r;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      // Idle levels, so reset never fakes a low mode select
      meta_r     <= `PAD_SYNC_RESET;
      sync_r     <= `PAD_SYNC_RESET;
      tck_prev_r <= 1'b0;
      reserve_r  <= 1'b0;
    end else begin
      meta_r     <= {tdo_pad_in, tms_pad_in, tdi_pad_in, tck_pad_in};
      sync_r     <= meta_r;
      tck_prev_r <= sync_r[0];
      reserve_r  <= reserve_pins_in;
    end
  end

  // ----------------------------------------
  // Mode ownership
  // ----------------------------------------
  reg  test_mode_r;
  reg  test_mode_nxt;
  wire tap_live = reserve_r | test_mode_r;
  // Mode select reaches TAP only while scan owns pins
  wire tms_tap = tap_live ? tms_s : 1'b1;

  tap_fsm u_tap (
    .sys_clk_in  (sys_clk_in),
    .sys_rst_in  (sys_rst_in),
    .tck_rise_in (tck_rise),
    .mode_sel_in (tms_tap),
    .state_out   (tap_state_out)
  );

  always @* begin
    test_mode_nxt = test_mode_r;
    if (reserve_r) begin
      test_mode_nxt = 1'b1;
    end else if (!test_mode_r) begin
      // Flexible: capture low mode select only
      if (!tms_s) begin
        test_mode_nxt = 1'b1;
      end
    end else if (tck_rise && tap_state_out == `TAP_SEL_IR && tms_s) begin
      // This rise lands in logic reset
      test_mode_nxt = 1'b0;
    end else if (tap_state_out == `TAP_RESET && tms_s) begin
      test_mode_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // Instruction and data shift paths
  // ----------------------------------------
  reg  [`IR_W-1:0]  ir_shift_r;
  reg  [`IR_W-1:0]  ir_r;
  reg  [`BSR_W-1:0] bsr_shift_r;
  reg               bypass_r;
  reg               tdo_r;
  reg               tdo_en_r;
  wire              shifting_ir = tap_state_out == `TAP_SHIFT_IR;
  wire              shifting_dr = tap_state_out == `TAP_SHIFT_DR;

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      test_mode_r    <= 1'b0;
      ir_shift_r     <= `IR_CAPTURE;
      ir_r           <= `IR_BYPASS;
      bsr_shift_r    <= {`BSR_W{1'b0}};
      bsr_update_out <= {`BSR_W{1'b0}};
      bypass_r       <= 1'b0;
      tdo_r          <= 1'b0;
      tdo_en_r       <= 1'b0;
    end else begin
      test_mode_r <= test_mode_nxt;
      if (tap_state_out == `TAP_RESET) begin
        ir_r <= `IR_BYPASS;
      end
      if (tck_rise) begin
        case (tap_state_out)
          `TAP_CAP_IR:   ir_shift_r  <= `IR_CAPTURE;
          `TAP_SHIFT_IR: ir_shift_r  <= {tdi_s, ir_shift_r[`IR_W-1:1]};
          `TAP_UPD_IR:   ir_r        <= ir_shift_r;
          `TAP_CAP_DR: begin
            bsr_shift_r <= bsr_capture_in;
            bypass_r    <= 1'b0;
          end
          `TAP_SHIFT_DR: begin
            bsr_shift_r <= {tdi_s, bsr_shift_r[`BSR_W-1:1]};
            bypass_r    <= tdi_s;
          end
          `TAP_UPD_DR: begin
            if (ir_r == `IR_SCAN) begin
              bsr_update_out <= bsr_shift_r;
            end
          end
          default: begin
          end
        endcase
      end
      // Output changes on falling edge, as the TAP convention expects
      if (tck_fall) begin
        tdo_en_r <= shifting_ir | shifting_dr;
        if (shifting_ir) begin
          tdo_r <= ir_shift_r[0];
        end else if (ir_r == `IR_SCAN) begin
          tdo_r <= bsr_shift_r[0];
        end else begin
          tdo_r <= bypass_r;
        end
      end
    end
  end

  // ----------------------------------------
  // Pad multiplexing
  // ----------------------------------------
  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      {tck_pad_out, tdi_pad_out, tms_pad_out, tdo_pad_out} <= 4'h0;
      {tck_pad_oe_out, tdi_pad_oe_out, tms_pad_oe_out, tdo_pad_oe_out} <= 4'h0;
      user_in_out     <= 4'h0;
      test_active_out <= 1'b0;
    end else begin
      test_active_out <= tap_live;
      user_in_out     <= sync_r;
      if (tap_live) begin
        // Clock and data in stay released; data out drives, mode select only as a user pin
        tck_pad_out    <= 1'b0;
        tck_pad_oe_out <= 1'b0;
        tdi_pad_out    <= 1'b0;
        tdi_pad_oe_out <= 1'b0;
        tdo_pad_out    <= tdo_r;
        tdo_pad_oe_out <= tdo_en_r;
        // Mode select keeps user role in flexible mode only
        tms_pad_out    <= reserve_r ? 1'b0 : user_out_in[2];
        tms_pad_oe_out <= reserve_r ? 1'b0 : user_oe_in[2];
      end else begin
        tck_pad_out    <= user_out_in[0];
        tck_pad_oe_out <= user_oe_in[0];
        tdi_pad_out    <= user_out_in[1];
        tdi_pad_oe_out <= user_oe_in[1];
        tms_pad_out    <= user_out_in[2];
        tms_pad_oe_out <= user_oe_in[2];
        tdo_pad_out    <= user_out_in[3];
        tdo_pad_oe_out <= user_oe_in[3];
      end
    end
  end
endmodule // shared_boundary_scan_pins

//--- inc/scan_pins_consts.vh
`ifndef SCAN_PINS_CONSTS_VH
`define SCAN_PINS_CONSTS_VH
// TAP controller state codes, one-hot
`define TAP_W            16
`define TAP_RESET        16'h0001
`define TAP_IDLE         16'h0002
`define TAP_SEL_DR       16'h0004
`define TAP_CAP_DR       16'h0008
`define TAP_SHIFT_DR     16'h0010
`define TAP_EXIT1_DR     16'h0020
`define TAP_PAUSE_DR     16'h0040
`define TAP_EXIT2_DR     16'h0080
`define TAP_UPD_DR       16'h0100
`define TAP_SEL_IR       16'h0200
`define TAP_CAP_IR       16'h0400
`define TAP_SHIFT_IR     16'h0800
`define TAP_EXIT1_IR     16'h1000
`define TAP_PAUSE_IR     16'h2000
`define TAP_EXIT2_IR     16'h4000
`define TAP_UPD_IR       16'h8000
// Register widths and reset values
`define IR_W             4
`define IR_CAPTURE       4'h1
`define IR_BYPASS        4'hF
`define IR_SCAN          4'h0
`define BSR_W            4
// Idle pad levels: mode select high, test clock low
`define PAD_SYNC_RESET   4'h4
`define RESET_TCK_CYCLES 5
`endif

//--- hw/tap_fsm.v
`timescale 1ns/1ps
`include "scan_pins_consts.vh"
module tap_fsm (
  input  wire                  sys_clk_in,
  input  wire                  sys_rst_in,
  input  wire                  tck_rise_in,
  input  wire                  mode_sel_in,
  output reg  [`TAP_W-1:0]     state_out
);
  reg [`TAP_W-1:0] state_nxt;
  // ----------------------------------------
  // Standard sixteen-state walk
  // ----------------------------------------
  always @* begin
    case (state_out)
      `TAP_RESET:    state_nxt = mode_sel_in ? `TAP_RESET   : `TAP_IDLE;
      `TAP_IDLE:     state_nxt = mode_sel_in ? `TAP_SEL_DR  : `TAP_IDLE;
      `TAP_SEL_DR:   state_nxt = mode_sel_in ? `TAP_SEL_IR  : `TAP_CAP_DR;
      `TAP_CAP_DR:   state_nxt = mode_sel_in ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: state_nxt = mode_sel_in ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: state_nxt = mode_sel_in ? `TAP_UPD_DR  : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: state_nxt = mode_sel_in ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: state_nxt = mode_sel_in ? `TAP_UPD_DR  : `TAP_SHIFT_DR;
      `TAP_UPD_DR:   state_nxt = mode_sel_in ? `TAP_SEL_DR  : `TAP_IDLE;
      `TAP_SEL_IR:   state_nxt = mode_sel_in ? `TAP_RESET   : `TAP_CAP_IR;
      `TAP_CAP_IR:   state_nxt = mode_sel_in ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: state_nxt = mode_sel_in ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: state_nxt = mode_sel_in ? `TAP_UPD_IR  : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: state_nxt = mode_sel_in ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: state_nxt = mode_sel_in ? `TAP_UPD_IR  : `TAP_SHIFT_IR;
      `TAP_UPD_IR:   state_nxt = mode_sel_in ? `TAP_SEL_DR  : `TAP_IDLE;
      default:       state_nxt = `TAP_RESET;
    endcase
  end

  always @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_out <= `TAP_RESET;
    end else if (tck_rise_in) begin
      state_out <= state_nxt;
    end
  end
endmodule // tap_fsm

//--- verification/scan_pins_chk_sva.sv
`timescale 1ns/1ps
`include "scan_pins_consts.vh"
module scan_pins_chk (
  input wire              sys_clk_in,
  input wire              sys_rst_in,
  input wire              reserve_pins_in,
  input wire              tms_pad_in,
  input wire              tck_pad_out,
  input wire              tck_pad_oe_out,
  input wire              tdi_pad_oe_out,
  input wire              tdo_pad_oe_out,
  input wire [3:0]        user_out_in,
  input wire [3:0]        user_oe_in,
  input wire              test_active_out,
  input wire [`TAP_W-1:0] tap_state_out
);
  // Exit1 allowed: the enable may drop only at the next test clock fall
  localparam [15:0] SH = `TAP_SHIFT_IR | `TAP_SHIFT_DR | `TAP_EXIT1_IR | `TAP_EXIT1_DR;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ---------------
  // Pin ownership
  // ---------------
  a_user_mirror: assert property (!test_active_out && !$past(test_active_out) && !$past(sys_rst_in) |->
    tck_pad_out == $past(user_out_in[0]) && tck_pad_oe_out == $past(user_oe_in[0])) else $error("user pin");
  a_test_inputs: assert property (test_active_out && $past(test_active_out) |->
    !tck_pad_oe_out && !tdi_pad_oe_out) else $error("test pin driven");
  a_enter_test: assert property ((!reserve_pins_in && !tms_pad_in)[*6] |-> test_active_out)
    else $error("no test entry");
  a_held_flex: assert property ((!reserve_pins_in && tms_pad_in && !test_active_out)[*4] |->
    tap_state_out == `TAP_RESET) else $error("tap moved");
  a_stay_test: assert property (test_active_out && tap_state_out != `TAP_RESET |=> test_active_out)
    else $error("early release");
  a_release: assert property ((!reserve_pins_in && tms_pad_in && tap_state_out == `TAP_RESET)[*5]
    |-> !test_active_out) else $error("no release");
  a_dedicated: assert property (reserve_pins_in[*3] |-> test_active_out) else $error("dedicated");
  a_tdo_shift: assert property (tdo_pad_oe_out && test_active_out |->
    (tap_state_out & SH) != 0 || ($past(tap_state_out) & SH) != 0) else $error("tdo enable");
  c_shift: cover property (tdo_pad_oe_out && test_active_out);
  c_release: cover property ($fell(test_active_out));
  c_dedic: cover property (reserve_pins_in && tap_state_out == `TAP_IDLE);
endmodule // scan_pins_chk
bind shared_boundary_scan_pins scan_pins_chk chk (.*);

//--- verification/scan_tester.sv
`timescale 1ns/1ps
module scan_tester (
  input  wire tdo_in,
  output reg  tck_out,
  output reg  tdi_out,
  output reg  tms_out
);
  // ---------------
  // Test clock frames
  // ---------------
  initial begin
    tck_out = 1'b0;
    tdi_out = 1'b0;
    tms_out = 1'b1;
  end
  // Clock stands low between steps; 125 ns period, no phase tie to sys clock
  task step(input reg m, input reg d, output reg q);
    begin
      tms_out = m;
      tdi_out = d;
      #62.5 tck_out = 1'b1;
      q = tdo_in;
      #62.5 tck_out = 1'b0;
    end
  endtask
endmodule // scan_tester

//--- verification/shared_boundary_scan_pins_test.sv
`timescale 1ns/1ps
`include "scan_pins_consts.vh"
module shared_boundary_scan_pins_test;
  reg         sys_clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         reserve = 1'b0;
  reg  [3:0]  u_out = 4'hE;
  reg  [3:0]  u_oe = 4'h0;
  reg  [3:0]  cap = 4'h6;
  reg         tdo_last = 1'b0;
  reg         q;
  reg  [3:0]  got;
  integer     i;
  integer     n_mismatch = 0;
  integer     n_tests = 0;
  wire [3:0]  p_o, p_oe, u_in, upd;
  wire [15:0] st;
  wire        t_tck, t_tdi, t_tms, act;
  wire        tck_w = p_oe[0] ? p_o[0] : t_tck;
  wire        tdi_w = p_oe[1] ? p_o[1] : t_tdi;
  wire        tms_w = p_oe[2] ? p_o[2] : t_tms;
  // Undriven pin shows no stale value
  wire        tdo_w = p_oe[3] ? p_o[3] : ~tdo_last;
  shared_boundary_scan_pins DUT (
    .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .reserve_pins_in(reserve),
    .tck_pad_in(tck_w), .tdi_pad_in(tdi_w), .tms_pad_in(tms_w), .tdo_pad_in(tdo_w),
    .tck_pad_out(p_o[0]), .tck_pad_oe_out(p_oe[0]), .tdi_pad_out(p_o[1]), .tdi_pad_oe_out(p_oe[1]),
    .tms_pad_out(p_o[2]), .tms_pad_oe_out(p_oe[2]), .tdo_pad_out(p_o[3]), .tdo_pad_oe_out(p_oe[3]),
    .user_out_in(u_out), .user_oe_in(u_oe), .user_in_out(u_in), .bsr_capture_in(cap),
    .bsr_update_out(upd), .test_active_out(act), .tap_state_out(st));
  scan_tester tester (.tdo_in(tdo_w), .tck_out(t_tck), .tdi_out(t_tdi), .tms_out(t_tms));
  // ---------------
  // Helpers and scenarios
  // ---------------
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (p_oe[3]) tdo_last <= p_o[3];
  task check(input [15:0] s, input [15:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, s, e);
      end
    end
  endtask
  task walk(input [7:0] m, input integer n);
    begin
      for (i = 0; i < n; i = i + 1) tester.step(m[i], 1'b0, q);
      repeat (4) @(negedge sys_clk);
    end
  endtask
  // LSB first; last bit leaves the shift state
  task shift4(input [3:0] d);
    begin
      for (i = 0; i < 4; i = i + 1) tester.step(i == 3, d[i], got[i]);
    end
  endtask
  task t_user;
    begin
      u_oe = 4'hF;
      repeat (4) @(negedge sys_clk);
      check(p_o, 4'hE);
      check(p_oe, 4'hF);
      check(u_in, 4'hE);
      u_oe = 4'h8;
      walk(8'hFF, 3);
      check(st, `TAP_RESET);
      check(act, 1'b0);
      check(p_oe, 4'h8);
      check(p_o[3], 1'b1);
      u_oe = 4'h0;
    end
  endtask
  task t_scan;
    begin
      walk(8'h06, 5);
      check(act, 1'b1);
      shift4(`IR_SCAN);
      check(got, `IR_CAPTURE);
      walk(8'h05, 5);
      shift4(4'h9);
      check(got, cap);
      walk(8'h01, 2);
      check(upd, 4'h9);
      check(st, `TAP_IDLE);
    end
  endtask
  task t_release;
    begin
      u_oe = 4'h1;
      walk(8'h01, 3);
      walk(8'h0F, 4);
      check(act, 1'b1);
      check(p_oe[0], 1'b0);
      walk(8'h01, 1);
      check(st, `TAP_RESET);
      check(act, 1'b0);
      check(p_oe[0], 1'b1);
      u_oe = 4'h0;
    end
  endtask
  task t_dedicated;
    begin
      reserve = 1'b1;
      walk(8'h1F, 5);
      check(st, `TAP_RESET);
      check(act, 1'b1);
      walk(8'h00, 1);
      check(st, `TAP_IDLE);
      // Logic reset restored bypass: one-bit delay, update left alone
      walk(8'h01, 3);
      shift4(4'h5);
      check(got, 4'hA);
      walk(8'h01, 2);
      check(upd, 4'h3);
      check(st, `TAP_IDLE);
    end
  endtask
  task wrap_up;
    begin
      if (n_mismatch == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    t_user;
    t_scan;
    t_release;
    t_dedicated;
    wrap_up;
  end
endmodule // shared_boundary_scan_pins_test
